// ==== hw/t8_timer.sv ====
// one 8-bit timer/event counter channel with its registers
`timescale 1ns/1ns
`include "t8_map.svh"
module t8_timer
  import t8_pkg::*;
#(
  parameter int CHANNEL = 0
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic [15:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  input wire logic event_input_pin_in,
  input wire logic subclk_in,
  input wire logic subclk_x4_in,
  output logic match_interrupt_out,
  output logic timer_output_pin_out,
  output logic timer_output_oe_n_out
);
  localparam logic [15:0] A_CNT = (CHANNEL == 0) ?
    `T8_CH0_COUNT_ADDR : `T8_CH1_COUNT_ADDR;
  localparam logic [15:0] A_MAT = (CHANNEL == 0) ?
    `T8_CH0_MATCH_ADDR : `T8_CH1_MATCH_ADDR;
  localparam logic [15:0] A_CS = (CHANNEL == 0) ?
    `T8_CH0_CLKSEL_ADDR : `T8_CH1_CLKSEL_ADDR;
  localparam logic [15:0] A_MC = (CHANNEL == 0) ?
    `T8_CH0_MODE_ADDR : `T8_CH1_MODE_ADDR;
  localparam int DIV0 = (CHANNEL == 0) ?
    `T8_CH0_DIV0_SHIFT : `T8_CH1_DIV0_SHIFT;

  t8_state_s st_r;
  t8_state_s st_nxt;
  logic [3:0] pre_tick;
  logic [2:0] agree;
  logic [2:0] new_lvl;
  logic [2:0] rise;
  logic [2:0] fall;
  logic tk;
  logic hit_cnt;
  logic hit_mat;
  logic hit_cs;
  logic hit_mc;
  logic rd_cnt;
  logic wr_mc;
  logic ext_clk;
  logic at_match;
  logic step;

  // divided subsystem clock ticks, reset while count enable is clear
  t8_prescaler #(
    .DIV0_SHIFT(DIV0)
  ) u_pre (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .run_in(st_r.ce),
    .step_in(rise[1]),
    .tick_out(pre_tick)
  );

  // pin levels count once the second and third stages agree
  always_comb begin
    agree = ~(st_r.s2 ^ st_r.s3);
    new_lvl = (agree & st_r.s3) | (~agree & st_r.lvl);
    rise = new_lvl & ~st_r.lvl;
    fall = ~new_lvl & st_r.lvl;
  end

  // address decode for the four byte registers
  always_comb begin
    hit_cnt = (addr_in == A_CNT);
    hit_mat = (addr_in == A_MAT);
    hit_cs = (addr_in == A_CS);
    hit_mc = (addr_in == A_MC);
    rd_cnt = rd_in & hit_cnt;
    wr_mc = wr_in & hit_mc;
  end

  // count clock selection
  always_comb begin
    case (st_r.csel)
      `T8_SEL_FALL: tk = fall[0];
      `T8_SEL_RISE: tk = rise[0];
      `T8_SEL_X4: tk = rise[2];
      `T8_SEL_SUB: tk = rise[1];
      `T8_SEL_DIV0: tk = pre_tick[0];
      `T8_SEL_DIV1: tk = pre_tick[1];
      `T8_SEL_DIV2: tk = pre_tick[2];
      `T8_SEL_DIV3: tk = pre_tick[3];
      default: tk = 1'b0;
    endcase
    ext_clk = (st_r.csel == `T8_SEL_FALL) || (st_r.csel == `T8_SEL_RISE);
    at_match = !st_r.pwm && (st_r.count == st_r.match);
  end

  // next state: sync, run control, counting, registers, output
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = {subclk_x4_in, subclk_in, event_input_pin_in};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.lvl = new_lvl;
    st_nxt.irq = 1'b0;
    step = 1'b0;
    case (st_r.run)
      T8_STOP: begin
        st_nxt.count = `T8_RESET_VAL;
        if (st_r.ce) begin
          st_nxt.run = T8_RUN;
        end
      end
      T8_RUN: begin
        if (!st_r.ce) begin
          st_nxt.run = T8_STOP;
          st_nxt.count = `T8_RESET_VAL;
        end else if (tk && rd_cnt) begin
          st_nxt.run = T8_HOLD;
        end else begin
          step = tk;
        end
      end
      T8_HOLD: begin
        if (!st_r.ce) begin
          st_nxt.run = T8_STOP;
          st_nxt.count = `T8_RESET_VAL;
        end else begin
          st_nxt.run = T8_RUN;
          step = 1'b1;
        end
      end
      default: begin
        st_nxt.run = T8_STOP;
      end
    endcase
    if (step) begin
      if (at_match) begin
        st_nxt.count = `T8_RESET_VAL;
        st_nxt.irq = 1'b1;
        if (st_r.inv) begin
          st_nxt.out_ff = ~st_r.out_ff;
        end
      end else begin
        st_nxt.count = st_r.count + 8'h01;
      end
    end
    // register writes
    if (wr_in && hit_mat) begin
      st_nxt.match = wdata_in;
    end
    if (wr_in && hit_cs) begin
      st_nxt.csel = wdata_in[2:0];
    end
    if (wr_mc) begin
      st_nxt.ce = wdata_in[`T8_MC_CE];
      st_nxt.pwm = wdata_in[`T8_MC_PWM];
      st_nxt.inv = wdata_in[`T8_MC_INV];
      st_nxt.oe = wdata_in[`T8_MC_OE];
      case ({wdata_in[`T8_MC_SET], wdata_in[`T8_MC_CLR]})
        2'b10: st_nxt.out_ff = 1'b1;
        2'b01: st_nxt.out_ff = 1'b0;
        default: st_nxt.out_ff = st_nxt.out_ff; // 11 prohibited
      endcase
    end
    // read data, captured on the read cycle
    if (rd_in) begin
      if (hit_cnt) begin
        st_nxt.rdata = st_r.count;
      end else if (hit_mat) begin
        st_nxt.rdata = st_r.match;
      end else if (hit_cs) begin
        st_nxt.rdata = {5'h00, st_r.csel};
      end else if (hit_mc) begin
        st_nxt.rdata = {st_r.ce, st_r.pwm, 4'h0, st_r.inv, st_r.oe};
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
    // output pin level and drive
    if (st_r.pwm) begin
      if (st_r.ce && (st_r.count < st_r.match)) begin
        st_nxt.pin = ~st_r.inv;
      end else begin
        st_nxt.pin = st_r.inv;
      end
    end else begin
      st_nxt.pin = st_r.out_ff;
    end
    st_nxt.pin_oe_n = ~(st_r.oe && !ext_clk);
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
      st_r.run <= T8_STOP;
      st_r.pin_oe_n <= 1'b1;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign match_interrupt_out = st_r.irq;
  assign timer_output_pin_out = st_r.pin;
  assign timer_output_oe_n_out = st_r.pin_oe_n;

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_step;
    ce_in && st_r.ce && !wr_mc && st_r.run == T8_RUN && tk && !rd_cnt;
  endsequence
  sequence s_hit;
    s_step ##0 at_match;
  endsequence
  // a count read on a tick, then the deferred step one cycle later
  sequence s_read_tick;
    ce_in && st_r.ce && !wr_mc && st_r.run == T8_RUN && tk && rd_cnt;
  endsequence
  sequence s_resume;
    !$past(ce_in) || (st_r.run == T8_RUN && st_r.count ==
      ($past(at_match) ? 8'h00 : 8'($past(st_r.count) + 8'h01)));
  endsequence

  count_step_a: assert property (
    s_step ##0 !at_match |=> st_r.count == 8'($past(st_r.count) + 8'h01))
    else $error("counter did not step on count clock");
  read_hold_a: assert property (
    s_read_tick
    |=> rdata_out == $past(st_r.count) && st_r.run == T8_HOLD
    ##1 s_resume)
    else $error("held count clock not applied after read");
  stop_clear_a: assert property (
    ce_in && !st_r.ce |=> st_r.count == 8'h00)
    else $error("counter not cleared while stopped");
  match_irq_a: assert property (
    s_hit |=> match_interrupt_out && st_r.count == 8'h00)
    else $error("match did not clear counter and interrupt");
  pwm_no_irq_a: assert property (
    ce_in && st_r.pwm |=> !match_interrupt_out)
    else $error("interrupt raised in pwm mode");
  match_write_a: assert property (
    ce_in && wr_in && hit_mat |=> st_r.match == $past(wdata_in))
    else $error("match value write lost");
  ff_set_a: assert property (
    ce_in && wr_mc && wdata_in[3:2] == 2'b10 |=> st_r.out_ff
    ##1 (!$past(ce_in) || $past(st_r.pwm) || timer_output_pin_out))
    else $error("flop set write not seen at pin");
  ff_clr_a: assert property (
    ce_in && wr_mc && wdata_in[3:2] == 2'b01 |=> !st_r.out_ff)
    else $error("flop reset write failed");
  wo_bits_a: assert property (
    ce_in && rd_in && hit_mc |=> rdata_out[3:2] == 2'b00)
    else $error("write-only bits read nonzero");
  pwm_stop_a: assert property (
    ce_in && st_r.pwm && !st_r.ce && !wr_mc
    |=> timer_output_pin_out == st_r.inv)
    else $error("pwm output not inactive when stopped");
  ext_no_out_a: assert property (
    ce_in && ext_clk |=> timer_output_oe_n_out)
    else $error("output driven with external count clock");
  toggle_a: assert property (
    s_hit ##0 st_r.inv |=> st_r.out_ff != $past(st_r.out_ff))
    else $error("output flop did not toggle on match");

  // register reads and clock select writes
  match_read_a: assert property (
    ce_in && rd_in && hit_mat |=> rdata_out == $past(st_r.match))
    else $error("match value read back wrong");
  csel_read_a: assert property (
    ce_in && rd_in && hit_cs |=> rdata_out == {5'h00, $past(st_r.csel)})
    else $error("clock select read back wrong");
  mode_read_a: assert property (
    ce_in && rd_in && hit_mc
    |=> rdata_out[7:6] == $past({st_r.ce, st_r.pwm})
    && rdata_out[1:0] == $past({st_r.inv, st_r.oe}))
    else $error("mode control read back wrong");
  csel_write_a: assert property (
    ce_in && wr_in && hit_cs |=> st_r.csel == $past(wdata_in[2:0]))
    else $error("clock select write lost");

  // run control while count enable is clear, and no interrupt without a step
  stop_state_a: assert property (
    ce_in && !st_r.ce |=> st_r.run == T8_STOP)
    else $error("counter still running with count enable clear");
  pre_off_a: assert property (
    ce_in && !st_r.ce |=> pre_tick == 4'h0)
    else $error("prescaler ticked with count enable clear");
  stop_no_irq_a: assert property (
    ce_in && !st_r.ce |=> !match_interrupt_out)
    else $error("interrupt raised while stopped");
  irq_step_a: assert property (
    ce_in && !step |=> !match_interrupt_out)
    else $error("interrupt raised without a count step");

  // output flop and pin drive
  ff_keep_a: assert property (
    ce_in && wr_mc && wdata_in[3] == wdata_in[2]
    && !(step && at_match && st_r.inv)
    |=> st_r.out_ff == $past(st_r.out_ff))
    else $error("flop moved on a no-change write");
  ff_follow_a: assert property (
    ce_in && !st_r.pwm |=> timer_output_pin_out == $past(st_r.out_ff))
    else $error("pin does not follow the output flop");
  pwm_active_a: assert property (
    ce_in && st_r.pwm && st_r.ce && st_r.count < st_r.match
    |=> timer_output_pin_out == !$past(st_r.inv))
    else $error("pwm output not at its active level");
  oe_on_a: assert property (
    ce_in && st_r.oe && !ext_clk |=> !timer_output_oe_n_out)
    else $error("enabled output not driven");
  oe_off_a: assert property (
    ce_in && !st_r.oe |=> timer_output_oe_n_out)
    else $error("pin driven with output disabled");
endmodule // t8_timer

// ==== shared/t8_map.svh ====
// register map, field positions, reset values and clock select codes
`ifndef T8_MAP_SVH
`define T8_MAP_SVH
`define T8_CH0_COUNT_ADDR 16'hff70
`define T8_CH0_MATCH_ADDR 16'hff71
`define T8_CH0_CLKSEL_ADDR 16'hff72
`define T8_CH0_MODE_ADDR 16'hff73
`define T8_CH1_COUNT_ADDR 16'hff78
`define T8_CH1_MATCH_ADDR 16'hff79
`define T8_CH1_CLKSEL_ADDR 16'hff7a
`define T8_CH1_MODE_ADDR 16'hff7b
`define T8_RESET_VAL 8'h00
`define T8_MC_CE 7
`define T8_MC_PWM 6
`define T8_MC_SET 3
`define T8_MC_CLR 2
`define T8_MC_INV 1
`define T8_MC_OE 0
`define T8_SEL_FALL 3'h0
`define T8_SEL_RISE 3'h1
`define T8_SEL_X4 3'h2
`define T8_SEL_SUB 3'h3
`define T8_SEL_DIV0 3'h4
`define T8_SEL_DIV1 3'h5
`define T8_SEL_DIV2 3'h6
`define T8_SEL_DIV3 3'h7
`define T8_CH0_DIV0_SHIFT 2
`define T8_CH1_DIV0_SHIFT 4
`define T8_DIV1_SHIFT 6
`define T8_DIV2_SHIFT 10
`define T8_DIV3_SHIFT 12
`endif

// ==== shared/t8_pkg.sv ====
// types shared by the timer channel and its prescaler
package t8_pkg;
  typedef enum logic [2:0] {
    T8_STOP = 3'b001,
    T8_RUN = 3'b010,
    T8_HOLD = 3'b100
  } t8_run_e;
  typedef struct packed {
    t8_run_e run;
    logic [7:0] count;
    logic [7:0] match;
    logic [2:0] csel;
    logic ce;
    logic pwm;
    logic inv;
    logic oe;
    logic out_ff;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] lvl;
    logic [7:0] rdata;
    logic irq;
    logic pin;
    logic pin_oe_n;
  } t8_state_s;
  typedef struct packed {
    logic [11:0] cnt;
    logic [3:0] tick;
  } t8_pre_s;
endpackage

// ==== hw/t8_prescaler.sv ====
// subsystem clock prescaler with four divided tick taps
`timescale 1ns/1ns
`include "t8_map.svh"
module t8_prescaler
  import t8_pkg::*;
#(
  parameter int DIV0_SHIFT = `T8_CH0_DIV0_SHIFT
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic run_in,
  input wire logic step_in,
  output logic [3:0] tick_out
);
  localparam int SH [4] = '{DIV0_SHIFT, `T8_DIV1_SHIFT,
                           `T8_DIV2_SHIFT, `T8_DIV3_SHIFT};
  t8_pre_s st_r;
  t8_pre_s st_nxt;
  logic [3:0] tap;

  // a tap fires when its low bits wrap on a subsystem clock edge
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_tap
      assign tap[i] = run_in & step_in & (&st_r.cnt[SH[i]-1:0]);
    end
  endgenerate

  // held at zero while counting is disabled
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = tap;
    if (!run_in) begin
      st_nxt.cnt = 12'h000;
    end else if (step_in) begin
      st_nxt.cnt = st_r.cnt + 12'h001;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  assign tick_out = st_r.tick;
endmodule // t8_prescaler

// ==== tb/t8_pin_partner.sv ====
// far side model: event source, subsystem clocks and the output pin
`timescale 1ns/1ns
module t8_pin_partner (
  input wire logic mclk_in,
  input wire logic pin_in,
  input wire logic oe_n_in,
  output logic event_out,
  output logic subclk_out,
  output logic subclk_x4_out,
  output logic level_out
);
  logic [2:0] div_r = 3'h0;
  // free running oscillators, period 8 and 4 clocks; x4 runs at twice
  // the sub rate since a one-clock level would not pass the pin filter
  always @(posedge mclk_in) begin
    div_r <= #1 div_r + 3'h1;
  end
  assign subclk_out = div_r[2];
  assign subclk_x4_out = div_r[1];
  // released pin is pulled up
  assign level_out = oe_n_in ? 1'b1 : pin_in;
  initial event_out = 1'b0;
  // n pulses, each four clocks low then four high, idle low
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge mclk_in);
      #1 event_out = 1'b1;
      repeat (4) @(posedge mclk_in);
      #1 event_out = 1'b0;
    end
  endtask
endmodule // t8_pin_partner

// ==== tb/t8_timer_test.sv ====
// self-checking bench for both timer channels
`timescale 1ns/1ns
module t8_timer_test;
  typedef struct {logic ch; logic [2:0] code; int gap;} t8_row_s;
  logic mclk = 1'b0;
  logic nrst_n, ce, rd, wr, ev, sub, x4, lvl0, irq0, irq1, pin0, oen0, p;
  logic pin1, oen1;
  logic [15:0] addr, b;
  logic [7:0] wdata, rd0, rd1;
  int fails, check_count, n;
  // clock select code and tick gap in clocks, x4 period 4, subclk 8
  // each code, x4 included, is written while the channel is stopped
  t8_row_s rows [7] = '{'{1'b0, 3'h2, 4}, '{1'b0, 3'h3, 8},
    '{1'b0, 3'h4, 32}, '{1'b0, 3'h5, 512}, '{1'b0, 3'h6, 8192},
    '{1'b0, 3'h7, 32768}, '{1'b1, 3'h4, 128}};

  always #4 mclk = ~mclk;

  // two channels on one register bus
  t8_timer #(.CHANNEL(0)) dut (.mclk_in(mclk), .nrst_in(nrst_n),
    .ce_in(ce), .addr_in(addr), .rd_in(rd), .wr_in(wr), .wdata_in(wdata),
    .rdata_out(rd0), .event_input_pin_in(ev), .subclk_in(sub),
    .subclk_x4_in(x4), .match_interrupt_out(irq0),
    .timer_output_pin_out(pin0), .timer_output_oe_n_out(oen0));
  t8_timer #(.CHANNEL(1)) dut1 (.mclk_in(mclk), .nrst_in(nrst_n),
    .ce_in(ce), .addr_in(addr), .rd_in(rd), .wr_in(wr), .wdata_in(wdata),
    .rdata_out(rd1), .event_input_pin_in(ev), .subclk_in(sub),
    .subclk_x4_in(x4), .match_interrupt_out(irq1),
    .timer_output_pin_out(pin1), .timer_output_oe_n_out(oen1));
  t8_pin_partner far (.mclk_in(mclk), .pin_in(pin0), .oe_n_in(oen0),
    .event_out(ev), .subclk_out(sub), .subclk_x4_out(x4),
    .level_out(lvl0));

  // compare and count
  task automatic chk(input logic [15:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one byte write, strobe for one cycle
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge mclk);
    #1 wr = 1'b0;
  endtask

  // one byte read, data valid the cycle after the strobe
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e,
                       input string what);
    @(posedge mclk);
    #1 addr = a;
    rd = 1'b1;
    @(posedge mclk);
    #1 rd = 1'b0;
    chk(a[3] ? rd1 : rd0, e, what);
  endtask

  // bounded wait for a match pulse
  task automatic wait_irq(input logic ch, input int bound);
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while ((ch ? irq1 : irq0) !== 1'b1 && n < bound);
    if ((ch ? irq1 : irq0) !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: no match pulse", $time);
      tally_and_finish();
    end
  endtask

  // settle two cycles then look at the pin level
  task automatic pin_is(input logic e);
    repeat (2) @(posedge mclk);
    #1 chk(lvl0, e, "pin");
  endtask

  initial begin
    nrst_n = 1'b0;
    ce = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    fails = 0;
    check_count = 0;
    repeat (12) @(posedge mclk);
    #1 nrst_n = 1'b1;
    // reset values, unmapped holes and a refused count write
    for (int i = 0; i < 16; i++) begin
      rdchk(16'hff70 + i[15:0], 8'h00, "reset value");
    end
    chk(oen0, 1'b1, "oe_n");
    chk(oen1, 1'b1, "oe_n ch1");
    chk(pin1, 1'b0, "pin ch1");
    wr8(16'hff70, 8'h5a);
    rdchk(16'hff70, 8'h00, "count written");
    $display("reset test done");
    // clock select codes 2 to 7, gap between two match pulses
    foreach (rows[i]) begin
      b = rows[i].ch ? 16'hff78 : 16'hff70;
      wr8(b + 16'h3, 8'h00);
      wr8(b + 16'h1, 8'h00);
      wr8(b + 16'h2, {5'h00, rows[i].code});
      rdchk(b + 16'h2, {5'h00, rows[i].code}, "clksel");
      wr8(b + 16'h3, 8'h80);
      wait_irq(rows[i].ch, 2 * rows[i].gap + 64);
      wait_irq(rows[i].ch, rows[i].gap + 8);
      chk(16'(n), 16'(rows[i].gap), "tick gap");
      wr8(b + 16'h3, 8'h00);
      $display("clock select test %0d done", i);
    end
    // interval mode with toggling output
    wr8(16'hff72, 8'h03);
    wr8(16'hff71, 8'h03);
    wr8(16'hff73, 8'h01);
    wr8(16'hff73, 8'h83);
    wait_irq(1'b0, 200);
    chk(oen0, 1'b0, "oe_n");
    wait_irq(1'b0, 200);
    chk(16'(n), 16'd32, "interval");
    repeat (2) @(posedge mclk);
    #1 p = lvl0;
    wait_irq(1'b0, 200);
    pin_is(~p);
    wr8(16'hff73, 8'h03);
    rdchk(16'hff70, 8'h00, "stopped count");
    wr8(16'hff73, 8'h0b);
    pin_is(1'b1);
    rdchk(16'hff73, 8'h03, "mode");
    wr8(16'hff73, 8'h07);
    pin_is(1'b0);
    $display("interval test done");
    // event counting on rising then falling edges
    wr8(16'hff72, 8'h01);
    wr8(16'hff71, 8'hff);
    wr8(16'hff73, 8'h83);
    repeat (2) @(posedge mclk);
    #1 chk(oen0, 1'b1, "oe_n events");
    // count reads held over every event edge defer, never lose, a step
    fork
      far.pulses(5);
      begin
        @(posedge mclk);
        #1 addr = 16'hff70;
        rd = 1'b1;
        repeat (40) @(posedge mclk);
        #1 rd = 1'b0;
      end
    join
    repeat (8) @(posedge mclk);
    rdchk(16'hff70, 8'h05, "rise count");
    wr8(16'hff73, 8'h03);
    wr8(16'hff72, 8'h00);
    wr8(16'hff73, 8'h83);
    far.pulses(3);
    repeat (8) @(posedge mclk);
    rdchk(16'hff70, 8'h03, "fall count");
    wr8(16'hff73, 8'h03);
    $display("event test done");
    // pwm, high then low active, stop drives inactive
    wr8(16'hff72, 8'h03);
    wr8(16'hff71, 8'h80);
    wr8(16'hff73, 8'h41);
    rdchk(16'hff73, 8'h41, "mode");
    wr8(16'hff73, 8'hc1);
    repeat (40) @(posedge mclk);
    pin_is(1'b1);
    wr8(16'hff73, 8'h41);
    pin_is(1'b0);
    wr8(16'hff73, 8'h43);
    pin_is(1'b1);
    wr8(16'hff73, 8'hc3);
    repeat (40) @(posedge mclk);
    pin_is(1'b0);
    wr8(16'hff71, 8'hff);
    rdchk(16'hff71, 8'hff, "match");
    wr8(16'hff73, 8'h43);
    $display("pwm test done");
    // reset in mid-run clears the mode, match and count registers again
    wr8(16'hff73, 8'hc3);
    @(posedge mclk);
    #1 nrst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 nrst_n = 1'b1;
    chk(oen0, 1'b1, "oe_n reset");
    chk(pin0, 1'b0, "pin reset");
    rdchk(16'hff73, 8'h00, "mode reset");
    rdchk(16'hff71, 8'h00, "match reset");
    rdchk(16'hff70, 8'h00, "count reset");
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule // t8_timer_test
